// ===== core/wps_pkg.sv
// wps_pkg: constants for the wavefront program state block
// assumes: single clock domain, one wavefront's state per instance
package wps_pkg;

  localparam int PC_WIDTH   = 48;
  localparam int MASK_WIDTH = 64;

  // status word field positions
  localparam int ST_SCC      = 0;
  localparam int ST_CPRIO_LO = 1;
  localparam int ST_PPRIO_LO = 3;
  localparam int ST_PRIV     = 5;
  localparam int ST_TRAPEN   = 6;
  localparam int ST_TTRACE   = 7;
  localparam int ST_EXPRDY   = 8;
  localparam int ST_EMZ      = 9;
  localparam int ST_CMZ      = 10;
  localparam int ST_INGRP    = 11;
  localparam int ST_BARRIER  = 12;
  localparam int ST_HALT     = 13;

  // mode word field positions
  localparam int MD_ROUND_LO  = 0;
  localparam int MD_DENORM_LO = 4;
  localparam int MD_NANCLAMP  = 8;
  localparam int MD_IEEE      = 9;
  localparam int MD_LODCLAMP  = 10;
  localparam int MD_DEBUG     = 11;
  localparam int MD_HALFOVF   = 23;
  localparam int MD_PERFDIS   = 26;
  localparam int MD_REGIDX    = 27;
  localparam int MD_VECTOR_SKIP     = 28;
  localparam int MD_BSP_LO    = 29;

  // reset values and instruction size
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [47:0] PC_RESET   = 48'h0000_0000_0000;
  localparam int          INSTR_BYTES = 4;

  // skip retirement capacity per clock
  localparam int SKIP_PER_CLK = 10;

  typedef enum logic [1:0] {
    RND_NEAREST_EVEN,
    RND_PLUS_INF,
    RND_MINUS_INF,
    RND_TO_ZERO
  } wps_round_t;

  typedef enum logic [1:0] {
    DN_FLUSH_BOTH,
    DN_ALLOW_IN,
    DN_ALLOW_OUT,
    DN_ALLOW_BOTH
  } wps_denorm_t;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_GET_PC,
    OP_SET_PC,
    OP_SWAP_PC,
    OP_BRANCH,
    OP_TRAP
  } wps_pcop_t;

endpackage

// ===== core/wps_skip_counter.sv
// wps_skip_counter: counts vector instructions retired by skipping
// assumes: caller presents the number of skip requests each clock
`timescale 1ns/1ps
module wps_skip_counter
  import wps_pkg::*;
#(
  parameter int CNT_WIDTH = 16
) (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 rstn,
  // requests
  input  wire logic [3:0]           skipReq,
  // outputs
  output logic      [3:0]           skipGranted,
  output logic      [CNT_WIDTH-1:0] skipCount
);

  logic [3:0] granted;

  always_comb begin
    if (skipReq > 4'(SKIP_PER_CLK)) begin
      granted = 4'(SKIP_PER_CLK);
    end else begin
      granted = skipReq;
    end
  end

  assign skipGranted = granted;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      skipCount <= '0;
    end else begin
      skipCount <= skipCount + CNT_WIDTH'(granted);
    end
  end

endmodule

// ===== core/wps_wavefront_state.sv
// wps_wavefront_state: program counter, thread enable mask, status and
// mode words of one wavefront
// assumes: instruction decode drives one-cycle strobes on the same clock;
// creation loads initial values; host and buffer levels come from pins
`timescale 1ns/1ps
module wps_wavefront_state
  import wps_pkg::*;
#(
  parameter int SREG_IDX_W = 7
) (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  rstn,
  // wavefront creation
  input  wire logic                  createWave,
  input  wire logic [PC_WIDTH-1:0]   createPc,
  input  wire logic [1:0]            createPrio,
  input  wire logic                  createTrapPresent,
  input  wire logic                  createTraceEnable,
  input  wire logic                  createInGroup,
  // pc instructions
  input  wire logic                  pcOpValid,
  input  wire wps_pcop_t             pcOp,
  input  wire logic [SREG_IDX_W-1:0] pcPairIdx,
  input  wire logic [PC_WIDTH-1:0]   pcPairData,
  input  wire logic [PC_WIDTH-1:0]   branchOffset,
  input  wire logic                  advancePc,
  output logic      [PC_WIDTH-1:0]   programCounter,
  output logic      [PC_WIDTH-1:0]   pcReadData,
  output logic                       pcReadValid,
  output logic                       pcAlignError,
  // thread enable mask
  input  wire logic                  maskWrite,
  input  wire logic [MASK_WIDTH-1:0] maskWriteData,
  input  wire logic                  cmpMaskUpdate,
  input  wire logic [MASK_WIDTH-1:0] cmpMaskData,
  input  wire logic                  cmpToEnable,
  output logic      [MASK_WIDTH-1:0] threadEnableMask,
  output logic      [MASK_WIDTH-1:0] compareMask,
  // instruction classification and gating
  input  wire logic                  instrValid,
  input  wire logic                  instrIsVector,
  input  wire logic                  instrIsExport,
  input  wire logic                  instrIsEndPgm,
  output logic      [MASK_WIDTH-1:0] laneEnable,
  output logic                       instrIssue,
  output logic                       instrSkip,
  output logic                       exportStall,
  output logic                       debugTrapReq,
  // scalar and status sources
  input  wire logic                  sccWrite,
  input  wire logic                  sccData,
  input  wire logic                  progPrioWrite,
  input  wire logic [1:0]            progPrioData,
  input  wire logic                  trapEnter,
  input  wire logic                  trapReturn,
  input  wire logic                  hostTrapReq,
  input  wire logic                  hostHaltPin,
  input  wire logic                  shaderHalt,
  input  wire logic                  exportSpacePin,
  input  wire logic                  barrierEnter,
  input  wire logic                  barrierRelease,
  input  wire logic                  traceDataValid,
  output logic                       traceDataKeep,
  output logic                       trapTaken,
  output logic                       trapRegWriteOk,
  output logic                       haltActive,
  output logic      [31:0]           waveStatus,
  // mode word
  input  wire logic                  modeWrite,
  input  wire logic [31:0]           modeWriteData,
  input  wire logic                  detailClampEvent,
  output logic      [31:0]           waveModeControl,
  output wps_round_t                 roundMode,
  output wps_denorm_t                denormMode,
  output logic                       nanClampEnable,
  output logic                       ieeeNanMode,
  // vector skip
  input  wire logic [3:0]            skipRequests,
  output logic      [3:0]            skipGranted,
  output logic      [15:0]           skipCount
);

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  logic [1:0] hostHaltSync_q;
  logic [1:0] expSpaceSync_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      hostHaltSync_q <= '0;
      expSpaceSync_q <= '0;
    end else begin
      hostHaltSync_q <= {hostHaltSync_q[0], hostHaltPin};
      expSpaceSync_q <= {expSpaceSync_q[0], exportSpacePin};
    end
  end

  // ------------------------------------------------------------------
  // program counter
  // ------------------------------------------------------------------
  logic [PC_WIDTH-1:0] pc_q;
  logic [PC_WIDTH-1:0] nextInstrPc;
  logic                pairAligned;
  logic                trapAllowed;

  assign nextInstrPc = pc_q + PC_WIDTH'(INSTR_BYTES);
  assign pairAligned = ~pcPairIdx[0];

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pc_q <= PC_RESET;
    end else if (createWave) begin
      pc_q <= createPc;
    end else if (pcOpValid && pcOp == OP_BRANCH) begin
      pc_q <= nextInstrPc + branchOffset;
    end else if (pcOpValid && pairAligned &&
                 (pcOp == OP_SET_PC || pcOp == OP_SWAP_PC)) begin
      pc_q <= pcPairData;
    end else if (advancePc) begin
      pc_q <= nextInstrPc;
    end
  end

  // pc read data: next-instruction pc for get/swap, own pc for trap
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pcReadData   <= '0;
      pcReadValid  <= 1'b0;
      pcAlignError <= 1'b0;
    end else begin
      pcReadValid  <= 1'b0;
      pcAlignError <= 1'b0;
      if (pcOpValid) begin
        unique case (pcOp)
          OP_GET_PC, OP_SWAP_PC: begin
            pcReadData   <= nextInstrPc;
            pcReadValid  <= pairAligned;
            pcAlignError <= ~pairAligned;
          end
          OP_SET_PC: begin
            pcAlignError <= ~pairAligned;
          end
          OP_TRAP: begin
            pcReadData  <= pc_q;
            pcReadValid <= trapAllowed;
          end
          default: begin
            pcReadValid <= 1'b0;
          end
        endcase
      end
    end
  end

  assign programCounter = pc_q;

  // ------------------------------------------------------------------
  // thread enable and compare masks
  // ------------------------------------------------------------------
  logic [MASK_WIDTH-1:0] enMask_q;
  logic [MASK_WIDTH-1:0] cmpMask_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      enMask_q <= '0;
    end else if (createWave) begin
      enMask_q <= '1;
    end else if (cmpMaskUpdate && cmpToEnable) begin
      enMask_q <= cmpMaskData & enMask_q;
    end else if (maskWrite) begin
      enMask_q <= maskWriteData;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cmpMask_q <= '0;
    end else if (createWave) begin
      cmpMask_q <= '0;
    end else if (cmpMaskUpdate) begin
      cmpMask_q <= cmpMaskData & enMask_q;
    end
  end

  assign threadEnableMask = enMask_q;
  assign compareMask      = cmpMask_q;

  // ------------------------------------------------------------------
  // status word
  // ------------------------------------------------------------------
  logic       status_scc_q;
  logic [1:0] status_cPrio_q;
  logic [1:0] status_pPrio_q;
  logic       status_priv_q;
  logic       status_trapEn_q;
  logic       status_trace_q;
  logic       status_expRdy_q;
  logic       status_inGrp_q;
  logic       status_barrier_q;
  logic       status_halt_q;

  assign trapAllowed = status_trapEn_q;

  // creation-time fields; shader has no write path to them
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      status_cPrio_q  <= '0;
      status_trapEn_q <= 1'b0;
      status_trace_q  <= 1'b0;
      status_inGrp_q  <= 1'b0;
    end else if (createWave) begin
      status_cPrio_q  <= createPrio;
      status_trapEn_q <= createTrapPresent;
      status_trace_q  <= createTraceEnable;
      status_inGrp_q  <= createInGroup;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      status_scc_q   <= 1'b0;
      status_pPrio_q <= '0;
    end else if (createWave) begin
      status_scc_q   <= 1'b0;
      status_pPrio_q <= '0;
    end else begin
      if (sccWrite) begin
        status_scc_q <= sccData;
      end
      if (progPrioWrite) begin
        status_pPrio_q <= progPrioData;
      end
    end
  end

  // privilege: set only on trap entry, cleared on return
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      status_priv_q <= 1'b0;
    end else if (createWave || trapReturn) begin
      status_priv_q <= 1'b0;
    end else if (trapTaken) begin
      status_priv_q <= 1'b1;
    end
  end

  // export ready: cleared at creation unless synced space is present, set once space arrives
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      status_expRdy_q <= 1'b0;
    end else if (expSpaceSync_q[1]) begin
      status_expRdy_q <= 1'b1;
    end else if (createWave) begin
      status_expRdy_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      status_barrier_q <= 1'b0;
    end else if (barrierEnter) begin
      status_barrier_q <= 1'b1;
    end else if (barrierRelease || createWave) begin
      status_barrier_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      status_halt_q <= 1'b0;
    end else if (hostHaltSync_q[1] || shaderHalt) begin
      status_halt_q <= 1'b1;
    end else if (createWave) begin
      status_halt_q <= 1'b0;
    end
  end

  always_comb begin
    waveStatus                             = '0;
    waveStatus[ST_SCC]                     = status_scc_q;
    waveStatus[ST_CPRIO_LO +: 2]           = status_cPrio_q;
    waveStatus[ST_PPRIO_LO +: 2]           = status_pPrio_q;
    waveStatus[ST_PRIV]                    = status_priv_q;
    waveStatus[ST_TRAPEN]                  = status_trapEn_q;
    waveStatus[ST_TTRACE]                  = status_trace_q;
    waveStatus[ST_EXPRDY]                  = status_expRdy_q;
    waveStatus[ST_EMZ]                     = ~|enMask_q;
    waveStatus[ST_CMZ]                     = ~|cmpMask_q;
    waveStatus[ST_INGRP]                   = status_inGrp_q;
    waveStatus[ST_BARRIER]                 = status_barrier_q;
    waveStatus[ST_HALT]                    = status_halt_q;
  end

  // ------------------------------------------------------------------
  // mode word
  // ------------------------------------------------------------------
  logic [31:0] mode_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mode_q <= MODE_RESET;
    end else if (createWave) begin
      mode_q <= MODE_RESET;
    end else begin
      if (modeWrite) begin
        mode_q <= modeWriteData;
      end
      if (detailClampEvent) begin
        mode_q[MD_LODCLAMP] <= 1'b1;
      end
    end
  end

  assign waveModeControl = mode_q;
  assign roundMode      = wps_round_t'(mode_q[MD_ROUND_LO +: 2]);
  assign denormMode     = wps_denorm_t'(mode_q[MD_DENORM_LO +: 2]);
  assign nanClampEnable = mode_q[MD_NANCLAMP];
  assign ieeeNanMode    = mode_q[MD_IEEE];

  // ------------------------------------------------------------------
  // issue, gating, trap and trace
  // ------------------------------------------------------------------
  logic vecSkip;
  logic haltEffective;

  assign vecSkip       = mode_q[MD_VECTOR_SKIP] & (instrIsVector | instrIsExport);
  assign haltEffective = status_halt_q & ~status_priv_q & ~hostTrapReq;
  assign haltActive    = haltEffective;

  // no automatic skip on an empty mask
  assign instrIssue  = instrValid & ~vecSkip & ~haltEffective
                     & ~exportStall;
  assign instrSkip   = instrValid & vecSkip & ~haltEffective;
  assign exportStall = instrValid & instrIsExport & ~vecSkip
                     & ~status_expRdy_q;

  // scalar ops and branches see all lanes on
  assign laneEnable = (instrIsVector | instrIsExport) ? enMask_q : '1;

  assign debugTrapReq = mode_q[MD_DEBUG] & instrIssue & ~instrIsEndPgm
                      & status_trapEn_q & ~status_priv_q;
  assign trapTaken = trapAllowed & ~status_priv_q
                   & (trapEnter | hostTrapReq | debugTrapReq
                      | (pcOpValid & pcOp == OP_TRAP));
  assign trapRegWriteOk = status_priv_q;
  assign traceDataKeep  = traceDataValid & status_trace_q;

  // ------------------------------------------------------------------
  // skip retirement
  // ------------------------------------------------------------------
  wps_skip_counter #(
    .CNT_WIDTH (16)
  ) u_skip (
    .clock       (clock),
    .rstn        (rstn),
    .skipReq     (skipRequests),
    .skipGranted (skipGranted),
    .skipCount   (skipCount)
  );

endmodule

// ===== sim/wps_wavefront_state_monitor.sv
// wps_wavefront_state_monitor: port-level checks on the wavefront state
// assumes: bound into wps_wavefront_state, one clock, rstn async low
`timescale 1ns/1ps
module wps_wavefront_state_monitor
  import wps_pkg::*;
#(
  parameter int SREG_IDX_W = 7
) (
  // clock and reset
  input wire logic                  clock,
  input wire logic                  rstn,
  // pc
  input wire logic                  createWave,
  input wire logic [PC_WIDTH-1:0]   createPc,
  input wire logic                  pcOpValid,
  input wire wps_pcop_t             pcOp,
  input wire logic [SREG_IDX_W-1:0] pcPairIdx,
  input wire logic [PC_WIDTH-1:0]   programCounter,
  input wire logic [PC_WIDTH-1:0]   pcReadData,
  input wire logic                  pcReadValid,
  input wire logic                  pcAlignError,
  // masks and instructions
  input wire logic [MASK_WIDTH-1:0] threadEnableMask,
  input wire logic [MASK_WIDTH-1:0] compareMask,
  input wire logic [MASK_WIDTH-1:0] laneEnable,
  input wire logic                  instrValid,
  input wire logic                  instrIsVector,
  input wire logic                  instrIsExport,
  input wire logic                  instrIsEndPgm,
  input wire logic                  instrIssue,
  input wire logic                  instrSkip,
  input wire logic                  exportStall,
  input wire logic                  debugTrapReq,
  // status and mode
  input wire logic                  hostTrapReq,
  input wire logic                  traceDataKeep,
  input wire logic                  trapTaken,
  input wire logic                  trapRegWriteOk,
  input wire logic                  haltActive,
  input wire logic [31:0]           waveStatus,
  input wire logic                  modeWrite,
  input wire logic [31:0]           modeWriteData,
  input wire logic [31:0]           waveModeControl,
  input wire logic [3:0]            skipRequests,
  input wire logic [3:0]            skipGranted
);
  // defined mode fields, sticky detail clamp left out
  localparam logic [31:0] MODE_DEF = 32'hFC80_0B33;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_create_pc_load: assert property (createWave |=>
    programCounter == $past(createPc))
    else $error("pc not loaded on creation");
  a_get_pc_next: assert property (pcOpValid && pcOp == OP_GET_PC &&
    !pcPairIdx[0] && !createWave |=>
    pcReadValid && pcReadData == $past(programCounter) + 48'h4)
    else $error("get pc value wrong");
  a_odd_pair_refused: assert property (pcOpValid && !createWave &&
    pcOp inside {OP_GET_PC, OP_SET_PC, OP_SWAP_PC} && pcPairIdx[0]
    |=> pcAlignError)
    else $error("odd pair not refused");
  a_mask_zero_flag: assert property (
    waveStatus[ST_EMZ] == (threadEnableMask == 64'h0))
    else $error("enable mask zero flag wrong");
  a_cmp_zero_flag: assert property (
    waveStatus[ST_CMZ] == (compareMask == 64'h0))
    else $error("compare zero flag wrong");
  a_lane_gating: assert property (instrValid &&
    (instrIsVector || instrIsExport) |-> laneEnable == threadEnableMask)
    else $error("vector lanes not gated");
  a_scalar_ungated: assert property (instrValid &&
    !instrIsVector && !instrIsExport |-> &laneEnable)
    else $error("scalar gated by mask");
  a_export_stall: assert property (instrValid && instrIsExport &&
    !waveStatus[ST_EXPRDY] && !waveModeControl[MD_VECTOR_SKIP] |-> exportStall)
    else $error("export not stalled");
  a_trap_suppress: assert property (!waveStatus[ST_TRAPEN]
    |-> !trapTaken && !debugTrapReq)
    else $error("trap taken without handler");
  a_debug_step: assert property (instrIssue && !instrIsEndPgm &&
    waveModeControl[MD_DEBUG] && waveStatus[ST_TRAPEN] |-> debugTrapReq)
    else $error("single step trap missing");
  a_halt_ignored: assert property (
    waveStatus[ST_PRIV] || hostTrapReq |-> !haltActive)
    else $error("halt not ignored");
  a_priv_trapregs: assert property (
    trapRegWriteOk == waveStatus[ST_PRIV])
    else $error("trap register access wrong");
  a_trace_discard: assert property (
    !waveStatus[ST_TTRACE] |-> !traceDataKeep)
    else $error("trace data kept");
  a_mode_write_read: assert property (modeWrite && !createWave |=>
    ((waveModeControl ^ $past(modeWriteData)) & MODE_DEF) == 32'h0)
    else $error("mode readback wrong");
  a_vector_skip_vector: assert property (instrValid && instrIsVector &&
    waveModeControl[MD_VECTOR_SKIP] |-> instrSkip)
    else $error("vector not skipped");
  a_skip_cap: assert property (skipGranted ==
    ((skipRequests > 4'hA) ? 4'hA : skipRequests))
    else $error("skip grant wrong");
endmodule

// ===== sim/tb_wps_wavefront_state.sv
// tb_wps_wavefront_state: directed scenarios for the wavefront state
// assumes: inputs driven on falling edges, checker bound below
`timescale 1ns/1ps
module tb_wps_wavefront_state
  import wps_pkg::*;
;
  logic        clock, rstn, createWave, createTrapPresent, createTraceEnable;
  logic        createInGroup, pcOpValid, advancePc, maskWrite, cmpMaskUpdate;
  logic        cmpToEnable, instrValid, instrIsVector, instrIsExport;
  logic        instrIsEndPgm, sccWrite, sccData, progPrioWrite, trapEnter;
  logic        trapReturn, hostTrapReq, hostHaltPin, shaderHalt;
  logic        exportSpacePin, barrierEnter, barrierRelease, traceDataValid;
  logic        modeWrite, detailClampEvent, pcReadValid, pcAlignError;
  logic        instrIssue, instrSkip, exportStall, debugTrapReq;
  logic        traceDataKeep, trapTaken, trapRegWriteOk, haltActive;
  logic        nanClampEnable, ieeeNanMode;
  logic [1:0]  createPrio, progPrioData;
  logic [3:0]  skipRequests, skipGranted;
  logic [6:0]  pcPairIdx;
  logic [15:0] skipCount, cnt0;
  logic [31:0] modeWriteData, waveStatus, waveModeControl;
  logic [47:0] createPc, pcPairData, branchOffset, programCounter;
  logic [47:0] pcReadData, pcExp;
  logic [63:0] maskWriteData, cmpMaskData, threadEnableMask;
  logic [63:0] compareMask, laneEnable;
  wps_pcop_t   pcOp;
  wps_round_t  roundMode;
  wps_denorm_t denormMode;
  int          mismatches = 0;
  int          total_checks = 0;
  int          cycles = 0;

  wps_wavefront_state dut (.*);

  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(negedge clock);
  endtask
  task automatic pc_op(input wps_pcop_t op, input logic [6:0] idx);
    pcOpValid = 1'h1;
    pcOp = op;
    pcPairIdx = idx;
    tick();
  endtask
  task automatic final_report;
    if (mismatches == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_create(input logic tp);
    createWave = 1'h1;
    createPc = 48'h0000_1234_5670;
    createPrio = 2'h3;
    createTrapPresent = tp;
    createTraceEnable = tp;
    createInGroup = 1'h1;
    tick();
    createWave = 1'h0;
    chk(programCounter, 48'h0000_1234_5670);
    chk(waveStatus[2:1], 2'h3);
    chk(waveStatus[ST_TRAPEN], tp);
    chk(waveStatus[ST_INGRP], 1'h1);
    chk(threadEnableMask, 64'hFFFF_FFFF_FFFF_FFFF);
  endtask
  task automatic t_pc;
    pcPairData = 48'h0000_00AB_CD00;
    branchOffset = 48'h0000_0000_0100;
    pcExp = programCounter;
    pc_op(OP_GET_PC, 7'h04);
    chk(pcReadValid, 1'h1);
    chk(pcReadData, pcExp + 48'h4);
    pc_op(OP_SET_PC, 7'h05);
    chk(pcAlignError, 1'h1);
    chk(programCounter, pcExp);
    pc_op(OP_SWAP_PC, 7'h06);
    chk(pcReadData, pcExp + 48'h4);
    chk(programCounter, 48'h0000_00AB_CD00);
    pc_op(OP_BRANCH, 7'h00);
    chk(programCounter, 48'h0000_00AB_CE04);
    pcOpValid = 1'h0;
    advancePc = 1'h1;
    tick();
    advancePc = 1'h0;
    chk(programCounter, 48'h0000_00AB_CE08);
  endtask
  task automatic t_mask;
    maskWrite = 1'h1;
    maskWriteData = 64'h0;
    tick();
    chk(waveStatus[ST_EMZ], 1'h1);
    instrValid = 1'h1;
    instrIsVector = 1'h1;
    #1;
    chk(laneEnable, 64'h0);
    chk({instrIssue, instrSkip}, 2'h2);
    instrIsVector = 1'h0;
    maskWriteData = 64'h0000_0000_0000_00F0;
    tick();
    maskWrite = 1'h0;
    chk(laneEnable, 64'hFFFF_FFFF_FFFF_FFFF);
    instrValid = 1'h0;
    cmpMaskUpdate = 1'h1;
    cmpMaskData = 64'h0000_0000_0000_0033;
    tick();
    chk(compareMask, 64'h0000_0000_0000_0030);
    chk(waveStatus[ST_CMZ], 1'h0);
    cmpMaskData = 64'h0000_0000_0000_000F;
    tick();
    chk(waveStatus[ST_CMZ], 1'h1);
    cmpMaskData = 64'h0000_0000_0000_0033;
    cmpToEnable = 1'h1;
    tick();
    cmpMaskUpdate = 1'h0;
    cmpToEnable = 1'h0;
    chk(threadEnableMask, 64'h0000_0000_0000_0030);
  endtask
  task automatic t_status;
    sccData = 1'h1;
    sccWrite = 1'h1;
    progPrioData = 2'h2;
    progPrioWrite = 1'h1;
    tick();
    sccWrite = 1'h0;
    progPrioWrite = 1'h0;
    chk(waveStatus[4:0], 5'h17);
    traceDataValid = 1'h1;
    instrValid = 1'h1;
    instrIsExport = 1'h1;
    #1;
    chk(traceDataKeep, 1'h1);
    chk(exportStall, 1'h1);
    traceDataValid = 1'h0;
    exportSpacePin = 1'h1;
    tick(3);
    chk({waveStatus[ST_EXPRDY], exportStall}, 2'h2);
    instrValid = 1'h0;
    instrIsExport = 1'h0;
    barrierEnter = 1'h1;
    tick();
    barrierEnter = 1'h0;
    chk(waveStatus[ST_BARRIER], 1'h1);
    shaderHalt = 1'h1;
    tick();
    shaderHalt = 1'h0;
    chk(haltActive, 1'h1);
    hostTrapReq = 1'h1;
    #1;
    chk(haltActive, 1'h0);
    hostTrapReq = 1'h0;
    trapEnter = 1'h1;
    #1;
    chk(trapTaken, 1'h1);
    tick();
    trapEnter = 1'h0;
    chk({waveStatus[ST_PRIV], trapRegWriteOk, haltActive}, 3'h6);
    trapReturn = 1'h1;
    tick();
    trapReturn = 1'h0;
    chk(trapRegWriteOk, 1'h0);
  endtask
  task automatic t_mode;
    modeWrite = 1'h1;
    for (int i = 0; i < 4; i++) begin
      modeWriteData = {26'h0, i[1:0], 2'h0, i[1:0]};
      tick();
      chk(roundMode, i[1:0]);
      chk(denormMode, i[1:0]);
    end
    modeWriteData = 32'hEC80_0300;
    tick();
    modeWrite = 1'h0;
    chk(waveModeControl, 32'hEC80_0300);
    chk({nanClampEnable, ieeeNanMode}, 2'h3);
    detailClampEvent = 1'h1;
    tick();
    detailClampEvent = 1'h0;
    chk(waveModeControl[MD_LODCLAMP], 1'h1);
    modeWriteData = 32'h0000_0C00;
    modeWrite = 1'h1;
    tick();
    chk(waveModeControl, 32'h0000_0C00);
    instrValid = 1'h1;
    #1;
    chk(debugTrapReq, 1'h1);
    instrIsEndPgm = 1'h1;
    #1;
    chk(debugTrapReq, 1'h0);
    instrIsEndPgm = 1'h0;
    modeWriteData = 32'h1000_0000;
    tick();
    modeWrite = 1'h0;
    instrIsVector = 1'h1;
    skipRequests = 4'hF;
    cnt0 = skipCount;
    #1;
    chk(instrSkip, 1'h1);
    chk(skipGranted, 4'hA);
    tick();
    skipRequests = 4'h0;
    instrValid = 1'h0;
    instrIsVector = 1'h0;
    chk(skipCount, cnt0 + 16'hA);
  endtask
  task automatic t_notrap;
    t_create(1'h0);
    modeWriteData = 32'h0000_0800;
    modeWrite = 1'h1;
    tick();
    modeWrite = 1'h0;
    instrValid = 1'h1;
    trapEnter = 1'h1;
    traceDataValid = 1'h1;
    #1;
    chk({debugTrapReq, trapTaken}, 2'h0);
    chk(traceDataKeep, 1'h0);
    tick();
    trapEnter = 1'h0;
    instrValid = 1'h0;
    traceDataValid = 1'h0;
    chk(waveStatus[ST_PRIV], 1'h0);
  endtask

  // ----------------------------------------------------------------
  // main sequence and hang guard
  // ----------------------------------------------------------------
  initial begin
    {rstn, createWave, createTrapPresent, createTraceEnable, createInGroup,
     pcOpValid, advancePc, maskWrite, cmpMaskUpdate, cmpToEnable, instrValid,
     instrIsVector, instrIsExport, instrIsEndPgm, sccWrite, sccData,
     progPrioWrite, trapEnter, trapReturn, hostTrapReq, hostHaltPin,
     shaderHalt, exportSpacePin, barrierEnter, barrierRelease,
     traceDataValid, modeWrite, detailClampEvent, createPrio, progPrioData,
     skipRequests, pcPairIdx, modeWriteData, createPc, pcPairData,
     branchOffset, maskWriteData, cmpMaskData} = '0;
    pcOp = OP_NONE;
    tick(12);
    rstn = 1'h1;
    t_create(1'h1);
    t_pc();
    t_mask();
    t_status();
    t_create(1'h1);
    t_mode();
    t_notrap();
    final_report();
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      final_report();
    end
  end
endmodule

bind wps_wavefront_state wps_wavefront_state_monitor #(
  .SREG_IDX_W(SREG_IDX_W)
) u_mon (.*);
